//--- design/vsi_top.sv
`timescale 1ns/10ps
`default_nettype none
module vsi_top
  import vsi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Oscillator control
  output logic oscillator_control_out
);
  vsi_req_t req;
  logic run_r;
  logic [PREC_W-1:0] prec_r;
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] div_r;
  logic mod_en_r;
  logic hold;
  logic tick_raw;
  logic tick;
  logic carry;
  logic hit_ctrl;
  logic hit_code;
  logic hit_div;
  logic wr_ctrl;
  logic wr_code;
  logic wr_div;
  logic wr_prec;
  logic [DATA_W-1:0] rd_mux;
  vsi_state_t state;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign hit_ctrl = (req.addr == OFS_CTRL);
  assign hit_code = (req.addr == OFS_CODE);
  assign hit_div = (req.addr == OFS_DIV);
  assign wr_ctrl = req.wr & hit_ctrl;
  assign wr_prec = wr_ctrl & ~run_r;
  assign wr_div = req.wr & hit_div & ~run_r;
  assign wr_code = req.wr & hit_code & run_r;
  assign hold = ~run_r;
  assign tick = tick_raw;
  assign state = run_r ? VSI_RUN : VSI_STOP;

  always_comb begin
    if (hit_ctrl) rd_mux = {28'h0000000, prec_r, run_r};
    else if (hit_code) rd_mux = {16'h0000, code_r};
    else if (hit_div) rd_mux = {16'h0000, div_r};
    else rd_mux = READ_ZERO;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      prec_r <= PREC_RESET;
      code_r <= CODE_RESET;
      div_r <= DIV_RESET;
      mod_en_r <= 1'b0;
      reg_rdata <= READ_ZERO;
      oscillator_control_out <= 1'b0;
    end else begin
      if (wr_ctrl) run_r <= req.wdata[RUN_BIT];
      if (wr_prec) prec_r <= req.wdata[PREC_LSB +: PREC_W];
      if (wr_code) code_r <= req.wdata[CODE_W-1:0];
      if (wr_div) div_r <= req.wdata[CODE_W-1:0];
      mod_en_r <= hold ? 1'b0 : ~mod_en_r;
      reg_rdata <= req.rd ? rd_mux : READ_ZERO;
      oscillator_control_out <= hold ? 1'b0 : carry;
    end
  end

  vsi_divider u_div (
    .mclk(mclk),
    .clr(hold),
    .en(mod_en_r),
    .divisor(div_r),
    .tick(tick_raw)
  );

  vsi_accum u_acc (
    .mclk(mclk),
    .clr(hold),
    .tick(tick),
    .code(code_r),
    .prec(prec_r),
    .carry(carry)
  );

  a_out_low_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    !run_r |=> !oscillator_control_out) else $error("output high while stopped");
  a_prec_locked: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && $past(run_r) |-> $stable(prec_r)) else $error("precision changed while running");
  a_div_locked: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r |=> $stable(div_r) || !$past(run_r)) else $error("divider changed while running");
  a_run_write: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && reg_addr == OFS_CTRL |=> run_r == $past(reg_wdata[RUN_BIT]))
    else $error("run bit not written");
  a_stop_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && reg_wr && reg_addr == OFS_CTRL |=> prec_r == $past(prec_r))
    else $error("stop write altered precision");
  a_go_fields: assert property (@(posedge mclk) disable iff (sys_rst)
    !run_r && reg_wr && reg_addr == OFS_CTRL |=> prec_r == $past(reg_wdata[PREC_LSB +: PREC_W]))
    else $error("fields not set with run");
  a_code_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    !run_r |=> $stable(code_r)) else $error("code written while stopped");
  a_div_reset: assert property (@(posedge mclk)
    sys_rst |=> div_r == DIV_RESET) else $error("divider reset wrong");
  a_read_upper: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd |=> reg_rdata[31:16] == 16'h0000) else $error("upper bits not zero");
  a_tick_rate: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && div_r == DIV_RESET && run_r |-> ##2 (tick || !run_r))
    else $error("tick rate wrong");
  c_start: cover property (@(posedge mclk) !run_r ##1 run_r);
  c_out_high: cover property (@(posedge mclk) oscillator_control_out);
  c_code_wr: cover property (@(posedge mclk) wr_code);
  c_stop: cover property (@(posedge mclk) state == VSI_RUN ##1 state == VSI_STOP);
endmodule : vsi_top
`default_nettype wire

//--- design/vsi_pkg.sv
package vsi_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CODE_W = 16;
  localparam int PREC_W = 3;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CODE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DIV = 4'h8;
  localparam int RUN_BIT = 0;
  localparam int PREC_LSB = 1;
  localparam logic [CODE_W-1:0] DIV_RESET = 16'h0001;
  localparam logic [CODE_W-1:0] DIV_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [PREC_W-1:0] PREC_RESET = 3'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } vsi_req_t;

  typedef enum logic [1:0] {
    VSI_STOP = 2'b00,
    VSI_HALF = 2'b01,
    VSI_RUN = 2'b11
  } vsi_state_t;
endpackage : vsi_pkg

//--- design/vsi_divider.sv
`timescale 1ns/10ps
`default_nettype none
module vsi_divider
  import vsi_pkg::*;
(
  // Clock and hold
  input wire logic mclk,
  input wire logic clr,
  // Module clock enable, one mclk cycle in two
  input wire logic en,
  // Divisor and tick
  input wire logic [CODE_W-1:0] divisor,
  output logic tick
);
  logic [CODE_W-1:0] cnt_r;
  logic [CODE_W-1:0] cnt_nxt;
  logic [CODE_W-1:0] eff_div;
  logic at_end;
  assign eff_div = (divisor == DIV_ZERO) ? DIV_RESET : divisor;
  assign at_end = (cnt_r >= eff_div - DIV_RESET);
  assign cnt_nxt = at_end ? DIV_ZERO : cnt_r + DIV_RESET;
  // Counts module clock cycles, not mclk cycles
  assign tick = at_end & en & ~clr;
  always_ff @(posedge mclk) begin
    if (clr) cnt_r <= DIV_ZERO;
    else if (en) cnt_r <= cnt_nxt;
  end
endmodule : vsi_divider
`default_nettype wire

//--- design/vsi_accum.sv
`timescale 1ns/10ps
`default_nettype none
module vsi_accum
  import vsi_pkg::*;
(
  // Clock and hold
  input wire logic mclk,
  input wire logic clr,
  // Step
  input wire logic tick,
  input wire logic [CODE_W-1:0] code,
  input wire logic [PREC_W-1:0] prec,
  // Carry bit
  output logic carry
);
  logic [CODE_W-1:0] mask;
  logic [CODE_W-1:0] acc_r;
  logic [CODE_W:0] sum;
  logic [CODE_W-1:0] msb;
  assign mask = {CODE_W{1'b1}} << prec;
  assign sum = {1'b0, acc_r} + {1'b0, code & mask};
  assign msb = {CODE_W{1'b0}};
  always_ff @(posedge mclk) begin
    if (clr) begin
      acc_r <= msb;
      carry <= 1'b0;
    end else if (tick) begin
      acc_r <= sum[CODE_W-1:0] & mask;
      carry <= sum[CODE_W];
    end
  end
endmodule : vsi_accum
`default_nettype wire

//--- bench/vsi_vcxo_model.sv
`timescale 1ns/10ps
`default_nettype none
module vsi_vcxo_model (
  // Clock and control line
  input wire logic mclk,
  input wire logic ctl,
  // Rising edges and high cycles seen
  output int rises,
  output int ones
);
  logic last = 1'b0;
  initial rises = 0;
  initial ones = 0;
  always @(posedge mclk) begin
    if (ctl === 1'b1 && last !== 1'b1) rises <= rises + 1;
    if (ctl === 1'b1) ones <= ones + 1;
    last <= ctl;
  end
endmodule : vsi_vcxo_model
`default_nettype wire

//--- bench/tb_vcxo_single_bit_interpolator.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vcxo_single_bit_interpolator;
  import vsi_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic osc_out;
  int rises, ones, r0, o0, bad_count = 0, checks = 0;
  vsi_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_control_out(osc_out));
  vsi_vcxo_model osc (.mclk(mclk), .ctl(osc_out), .rises(rises), .ones(ones));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      $display("unexpected %s expected %h seen %h", s, e, v);
      bad_count++;
    end
  endtask : cmp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp("reg_rdata", e, reg_rdata);
  endtask : rd
  // Counts rising edges of the control line over n cycles
  task automatic window(input int n, input int lo, input int hi);
    r0 = rises;
    repeat (n) @(posedge mclk);
    cmp("edge count in range", 32'h1, 32'(rises - r0 >= lo && rises - r0 <= hi));
  endtask : window
  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_CODE, 32'h0);
    rd(OFS_DIV, 32'h1);
    rd(4'hc, 32'h0);
    wr(OFS_CODE, 32'h1234);
    rd(OFS_CODE, 32'h0);
    wr(OFS_DIV, 32'h0);
    rd(OFS_DIV, 32'h0);
    wr(OFS_DIV, 32'hffff_0003);
    rd(OFS_DIV, 32'h3);
    wr(OFS_CTRL, 32'hffff_fffe);
    rd(OFS_CTRL, 32'he);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    wr(OFS_CODE, 32'hffff_8000);
    rd(OFS_CODE, 32'h8000);
    wr(OFS_DIV, 32'h5);
    rd(OFS_DIV, 32'h3);
    wr(OFS_CTRL, 32'hf);
    rd(OFS_CTRL, 32'h1);
    window(384, 31, 33);
    wr(OFS_CTRL, 32'he);
    rd(OFS_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    o0 = ones;
    repeat (50) @(posedge mclk);
    cmp("high cycles while stopped", 32'(o0), 32'(ones));
    wr(OFS_DIV, 32'h1);
    wr(OFS_CTRL, 32'hf);
    rd(OFS_CTRL, 32'hf);
    wr(OFS_CODE, 32'h007f);
    repeat (8) @(posedge mclk);
    window(1200, 0, 0);
    close_out();
  end
endmodule : tb_vcxo_single_bit_interpolator
`default_nettype wire
